// *** rtcc_calendar.sv ***
// weekday, month, century and year counters, time-step blocking, alarm registers
`timescale 1ns/1ns
module rtcc_calendar import rtcc_pkg::*; (
  // core clock and reset
  input wire logic clock,
  input wire logic srst,
  // link clock domain
  input wire logic link_clk,
  input wire logic link_srst,
  // serial front end byte port, link clock
  input wire logic link_access,
  input wire logic link_rd,
  input wire logic link_wr,
  input wire logic [7:0] link_addr,
  input wire logic [7:0] link_wdata,
  output logic [7:0] link_rdata,
  output logic link_done,
  output logic link_busy,
  // timebase and lower counters
  input wire logic tick_1hz,
  output logic time_step,
  output logic counting_blocked,
  input wire logic day_carry,
  input wire logic month_carry,
  input wire logic [6:0] cur_minute,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  // alarm
  input wire logic alarm_clear,
  output logic alarm_flag
);
  rtcc_xfer_if xf ();

  logic access_meta_q, access_sync_q;
  logic req_meta_q, req_sync_q, req_seen_q, ack_q;
  logic req_pulse, wr_now, step, pending_q, time_step_q;
  logic [2:0] dow_q;
  logic [4:0] month_q;
  logic century_q;
  logic [7:0] year_q;
  logic [7:0] minute_match_q, hour_match_q, date_match_q, dow_match_q;
  logic [7:0] rdata_q, rd_mux;
  logic [7:0] year_next;
  logic [4:0] month_next;
  logic [7:0] month_inc;

  // link-side request port
  rtcc_link_port u_link (
    .link_clk (link_clk),
    .link_srst (link_srst),
    .access (link_access),
    .rd (link_rd),
    .wr (link_wr),
    .addr (link_addr),
    .wdata (link_wdata),
    .rdata (link_rdata),
    .done (link_done),
    .busy (link_busy),
    .xf (xf.link)
  );

  // level and toggle crossings into the core clock
  always_ff @(posedge clock) begin
    if (srst) begin
      access_meta_q <= 1'b0;
      access_sync_q <= 1'b0;
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      access_meta_q <= xf.access_lvl;
      access_sync_q <= access_meta_q;
      req_meta_q <= xf.req_tgl;
      req_sync_q <= req_meta_q;
      req_seen_q <= req_sync_q;
    end
  end

  // addr, data and we are held by the link side, so stable here
  assign req_pulse = req_sync_q ^ req_seen_q;
  assign wr_now = req_pulse && xf.we;
  assign counting_blocked = access_sync_q;

  // step only when free; a held tick is served on release
  assign step = !access_sync_q && (tick_1hz || pending_q);

  // at most one stored tick; more during one access are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (access_sync_q) begin
      pending_q <= pending_q || tick_1hz;
    end else begin
      pending_q <= pending_q && tick_1hz; // tick beside a served pending waits one cycle
    end
  end

  // step pulse to the seconds chain outside
  always_ff @(posedge clock) begin
    if (srst) begin
      time_step_q <= 1'b0;
    end else begin
      time_step_q <= step;
    end
  end
  assign time_step = time_step_q;

  assign year_next = bcd_inc(year_q);
  // a call result cannot be part-selected, so the increment goes through a net
  assign month_inc = bcd_inc({3'h0, month_q});
  assign month_next = (month_q == MONTH_LAST) ? MONTH_RST : month_inc[4:0];

  // weekday counter; it carries no calendar meaning, only the sequence
  always_ff @(posedge clock) begin
    if (srst) begin
      dow_q <= DOW_RST;
    end else if (wr_now && xf.addr == ADDR_DOW) begin
      dow_q <= xf.wdata[2:0];
    end else if (day_carry) begin
      dow_q <= (dow_q >= DOW_LAST) ? 3'h0 : dow_q + 3'h1;
    end
  end

  // month with century flag; a host write wins over a carry in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      month_q <= MONTH_RST;
      century_q <= CENTURY_RST;
    end else if (wr_now && xf.addr == ADDR_MONTH) begin
      month_q <= xf.wdata[4:0];
      century_q <= xf.wdata[CENTURY_BIT];
    end else if (month_carry) begin
      month_q <= month_next;
      if (month_q == MONTH_LAST && year_q == YEAR_LAST) begin
        century_q <= ~century_q;
      end
    end
  end

  // year counter, advanced on the December wrap
  always_ff @(posedge clock) begin
    if (srst) begin
      year_q <= YEAR_RST;
    end else if (wr_now && xf.addr == ADDR_YEAR) begin
      year_q <= xf.wdata;
    end else if (month_carry && month_q == MONTH_LAST) begin
      year_q <= year_next;
    end
  end

  // alarm match registers; unused bits are not stored
  always_ff @(posedge clock) begin
    if (srst) begin
      minute_match_q <= MATCH_RST;
      hour_match_q <= MATCH_RST;
      date_match_q <= MATCH_RST;
      dow_match_q <= MATCH_RST;
    end else if (wr_now) begin
      if (xf.addr == ADDR_MIN_MATCH) begin
        minute_match_q <= xf.wdata & MIN_MATCH_MASK;
      end
      if (xf.addr == ADDR_HOUR_MATCH) begin
        hour_match_q <= xf.wdata & HOUR_MATCH_MASK;
      end
      if (xf.addr == ADDR_DATE_MATCH) begin
        date_match_q <= xf.wdata & DATE_MATCH_MASK;
      end
      if (xf.addr == ADDR_DOW_MATCH) begin
        dow_match_q <= xf.wdata & DOW_MATCH_MASK;
      end
    end
  end

  // read view; unused bits and foreign offsets read zero
  always_comb begin
    unique case (xf.addr)
      ADDR_DOW: rd_mux = {5'h00, dow_q} & DOW_MASK;
      ADDR_MONTH: rd_mux = {century_q, 2'h0, month_q & MONTH_MASK[4:0]};
      ADDR_YEAR: rd_mux = year_q;
      ADDR_MIN_MATCH: rd_mux = minute_match_q;
      ADDR_HOUR_MATCH: rd_mux = hour_match_q;
      ADDR_DATE_MATCH: rd_mux = date_match_q;
      ADDR_DOW_MATCH: rd_mux = dow_match_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // answer: data and ack toggle move together, data is stable before the link sees ack
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (req_pulse) begin
      rdata_q <= rd_mux;
      ack_q <= ~ack_q;
    end
  end
  assign xf.rdata = rdata_q;
  assign xf.ack_tgl = ack_q;

  // alarm compare and flag
  rtcc_alarm u_alarm (
    .clock (clock),
    .srst (srst),
    .minute_match (minute_match_q),
    .hour_match (hour_match_q),
    .date_match (date_match_q),
    .dow_match (dow_match_q),
    .cur_minute (cur_minute),
    .cur_hour (cur_hour),
    .cur_date (cur_date),
    .cur_dow (dow_q),
    .alarm_clear (alarm_clear),
    .alarm_flag (alarm_flag)
  );

  // checks of the counting and access behaviour
  sequence s_blocked_tick;
    access_sync_q && tick_1hz;
  endsequence
  sequence s_release;
    !access_sync_q ##0 $past(access_sync_q);
  endsequence

  property p_no_step_blocked;
    @(posedge clock) disable iff (srst) access_sync_q |=> !time_step;
  endproperty
  a_no_step_blocked: assert property (p_no_step_blocked) else $error("step while blocked");

  property p_tick_held;
    @(posedge clock) disable iff (srst) s_blocked_tick |=> pending_q;
  endproperty
  a_tick_held: assert property (p_tick_held) else $error("tick lost in access");

  property p_release_serves;
    @(posedge clock) disable iff (srst) s_release ##0 pending_q |=> time_step ##1 !pending_q;
  endproperty
  a_release_serves: assert property (p_release_serves) else $error("pending not served");

  property p_dow_wrap;
    @(posedge clock) disable iff (srst)
      day_carry && !wr_now && dow_q == DOW_LAST |=> dow_q == 3'h0;
  endproperty
  a_dow_wrap: assert property (p_dow_wrap) else $error("weekday did not wrap");

  property p_century_flip;
    @(posedge clock) disable iff (srst)
      month_carry && !wr_now && month_q == MONTH_LAST && year_q == YEAR_LAST
      |=> year_q == 8'h00 && month_q == MONTH_RST && century_q != $past(century_q);
  endproperty
  a_century_flip: assert property (p_century_flip) else $error("century not toggled");

  property p_month_read;
    @(posedge clock) disable iff (srst)
      req_pulse && !xf.we && xf.addr == ADDR_MONTH
      |=> rdata_q[6:5] == 2'h0 && rdata_q[CENTURY_BIT] == $past(century_q);
  endproperty
  a_month_read: assert property (p_month_read) else $error("month read wrong");

  property p_dow_read;
    @(posedge clock) disable iff (srst)
      req_pulse && !xf.we && xf.addr == ADDR_DOW |=> rdata_q == {5'h00, $past(dow_q)};
  endproperty
  a_dow_read: assert property (p_dow_read) else $error("weekday read wrong");

  property p_match_reset;
    @(posedge clock) disable iff (srst)
      $past(srst) |-> minute_match_q == MATCH_RST && dow_match_q == MATCH_RST;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("match reset wrong");

  property p_hour_match_write;
    @(posedge clock) disable iff (srst)
      wr_now && xf.addr == ADDR_HOUR_MATCH |=> hour_match_q[6] == 1'b0;
  endproperty
  a_hour_match_write: assert property (p_hour_match_write) else $error("unused bit kept");
endmodule : rtcc_calendar

// *** rtcc_pkg.sv ***
// calendar and alarm register block: shared constants, types and helpers
// Behaviour
// - weekday held in bits 2:0, values 0-6
// - century flag in month bit 7, resets 0
// - year 99 to 00 inverts century flag
// - month BCD: tens bit 4, units 3:0
// - year BCD: tens 7:4, units 3:0
// - time counting suspended during bus access
// - one missed tick stored, applied after access
// - alarm bit 7 is active-low enable, resets 1
// - minute match BCD in bits 6:0
// - hour match BCD in bits 5:0
// - date match BCD in bits 5:0
// - weekday match in bits 2:0
// - flag set when all enabled fields first match
// - flag held until cleared; re-set only on new match
package rtcc_pkg;
  // register offsets on the shared pointer
  localparam logic [7:0] ADDR_DOW = 8'h06;
  localparam logic [7:0] ADDR_MONTH = 8'h07;
  localparam logic [7:0] ADDR_YEAR = 8'h08;
  localparam logic [7:0] ADDR_MIN_MATCH = 8'h09;
  localparam logic [7:0] ADDR_HOUR_MATCH = 8'h0A;
  localparam logic [7:0] ADDR_DATE_MATCH = 8'h0B;
  localparam logic [7:0] ADDR_DOW_MATCH = 8'h0C;
  // field positions and writable-bit masks
  localparam int CENTURY_BIT = 7;
  localparam int MATCH_DIS_BIT = 7;
  localparam logic [7:0] DOW_MASK = 8'h07;
  localparam logic [7:0] MONTH_MASK = 8'h1F;
  localparam logic [7:0] MIN_MATCH_MASK = 8'hFF;
  localparam logic [7:0] HOUR_MATCH_MASK = 8'hBF;
  localparam logic [7:0] DATE_MATCH_MASK = 8'hBF;
  localparam logic [7:0] DOW_MATCH_MASK = 8'h87;
  // reset values
  localparam logic [2:0] DOW_RST = 3'h0;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic CENTURY_RST = 1'b0;
  localparam logic [7:0] MATCH_RST = 8'h80;
  // counting limits
  localparam logic [2:0] DOW_LAST = 3'h6;
  localparam logic [4:0] MONTH_LAST = 5'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;

  typedef enum logic {LINK_IDLE, LINK_WAIT} rtcc_link_state_type;

  // two-digit BCD increment, wraps 99 to 00
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [3:0] t;
    t = v[7:4] + 4'h1;
    if (v[3:0] == 4'h9) begin
      bcd_inc = (v[7:4] == 4'h9) ? 8'h00 : {t, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc
endpackage : rtcc_pkg

// *** rtcc_xfer_if.sv ***
// word handshake between the link-side port and the register core
`timescale 1ns/1ns
interface rtcc_xfer_if;
  logic req_tgl;
  logic ack_tgl;
  logic we;
  logic access_lvl;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport link (output req_tgl, we, access_lvl, addr, wdata, input ack_tgl, rdata);
  modport core (input req_tgl, we, access_lvl, addr, wdata, output ack_tgl, rdata);
endinterface : rtcc_xfer_if

// *** rtcc_link_port.sv ***
// link-clock side: takes byte requests and crosses them by toggle handshake
`timescale 1ns/1ns
module rtcc_link_port import rtcc_pkg::*; (
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_srst,
  // byte requests from the serial front end
  input wire logic access,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic done,
  output logic busy,
  // toward the core
  rtcc_xfer_if.link xf
);
  rtcc_link_state_type state_q;
  logic req_q, we_q, access_q, ack_meta_q, ack_sync_q, ack_seen_q, done_q;
  logic [7:0] addr_q, wdata_q, rdata_q;
  logic ack_edge;

  assign ack_edge = ack_sync_q ^ ack_seen_q;
  assign busy = (state_q == LINK_WAIT);
  assign done = done_q;
  assign rdata = rdata_q;
  assign xf.req_tgl = req_q;
  assign xf.we = we_q;
  assign xf.access_lvl = access_q;
  assign xf.addr = addr_q;
  assign xf.wdata = wdata_q;

  // ack synchroniser; the edge is taken from the second and third stages, never the first
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_seen_q <= 1'b0;
      access_q <= 1'b0;
    end else begin
      ack_meta_q <= xf.ack_tgl;
      ack_sync_q <= ack_meta_q;
      ack_seen_q <= ack_sync_q;
      access_q <= access; // registered so the core sees a clean level
    end
  end

  // addr and data stay put until the ack returns, so the core may sample late
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      state_q <= LINK_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        LINK_IDLE: begin
          if (rd || wr) begin
            addr_q <= addr;
            wdata_q <= wdata;
            we_q <= wr;
            req_q <= ~req_q;
            state_q <= LINK_WAIT;
          end
        end
        LINK_WAIT: begin
          if (ack_edge) begin
            rdata_q <= xf.rdata;
            done_q <= 1'b1;
            state_q <= LINK_IDLE;
          end
        end
      endcase
    end
  end

  property p_hold_while_busy;
    @(posedge link_clk) disable iff (link_srst)
      busy && !ack_edge |=> $stable(addr_q) && $stable(wdata_q) && $stable(req_q);
  endproperty
  a_hold_while_busy: assert property (p_hold_while_busy) else $error("request moved in flight");
endmodule : rtcc_link_port

// *** rtcc_alarm.sv ***
// alarm compare of the enabled match fields and the sticky alarm flag
`timescale 1ns/1ns
module rtcc_alarm import rtcc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // match registers and current time
  input wire logic [7:0] minute_match,
  input wire logic [7:0] hour_match,
  input wire logic [7:0] date_match,
  input wire logic [7:0] dow_match,
  input wire logic [6:0] cur_minute,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  input wire logic [2:0] cur_dow,
  // flag
  input wire logic alarm_clear,
  output logic alarm_flag
);
  logic minute_match_disable, hour_match_disable, date_match_disable, dow_match_disable;
  logic match_now, match_q, flag_q, rise;

  assign minute_match_disable = minute_match[MATCH_DIS_BIT];
  assign hour_match_disable = hour_match[MATCH_DIS_BIT];
  assign date_match_disable = date_match[MATCH_DIS_BIT];
  assign dow_match_disable = dow_match[MATCH_DIS_BIT];

  // value fields only; with every field disabled nothing can match
  assign match_now = !(minute_match_disable && hour_match_disable && date_match_disable
                       && dow_match_disable)
    && (minute_match_disable || minute_match[6:0] == cur_minute)
    && (hour_match_disable || hour_match[5:0] == cur_hour)
    && (date_match_disable || date_match[5:0] == cur_date)
    && (dow_match_disable || dow_match[2:0] == cur_dow);
  assign rise = match_now && !match_q;
  assign alarm_flag = flag_q;

  // only a fresh match sets the flag; a set beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      match_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      match_q <= match_now;
      if (rise) begin
        flag_q <= 1'b1;
      end else if (alarm_clear) begin
        flag_q <= 1'b0;
      end
    end
  end

  property p_set_on_rise;
    @(posedge clock) disable iff (srst) rise |=> alarm_flag;
  endproperty
  a_set_on_rise: assert property (p_set_on_rise) else $error("alarm not set");
  property p_no_reset_persist;
    @(posedge clock) disable iff (srst) !alarm_flag && match_q && match_now |=> !alarm_flag;
  endproperty
  a_no_reset_persist: assert property (p_no_reset_persist) else $error("alarm re-set");
  property p_held;
    @(posedge clock) disable iff (srst) alarm_flag && !alarm_clear |=> alarm_flag;
  endproperty
  a_held: assert property (p_held) else $error("alarm dropped");
endmodule : rtcc_alarm

// *** rtcc_host_model.sv ***
// host-side model: moves single bytes over the link port inside one access
`timescale 1ns/1ns
module rtcc_host_model (
  // link clock
  input wire logic link_clk,
  // requests toward the register block
  output logic link_access,
  output logic link_rd,
  output logic link_wr,
  output logic [7:0] link_addr,
  output logic [7:0] link_wdata,
  // answers from the register block
  input wire logic [7:0] link_rdata,
  input wire logic link_done,
  input wire logic link_busy,
  output logic stall_seen
);
  int gap = 0;
  logic is_rd = 1'b0;

  // idle lines at time zero
  initial begin
    link_access = 1'b0;
    link_rd = 1'b0;
    link_wr = 1'b0;
    link_addr = 8'h00;
    link_wdata = 8'h00;
    stall_seen = 1'b0;
  end

  // whole time range moved inside one access, kept well under a second
  task automatic set_access(input logic v);
    @(negedge link_clk);
    link_access = v;
    repeat (4) @(negedge link_clk);
  endtask : set_access

  // address and data held until done is seen; gap gives slow or prompt hosts
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge link_clk);
    link_addr = a;
    link_wdata = d;
    link_wr = we;
    link_rd = !we;
    is_rd = !we;
    // strobe taken at the next edge as busy is low; held to done it would be taken twice
    @(negedge link_clk);
    link_rd = 1'b0;
    link_wr = 1'b0;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_done !== 1'b1 && n < 40);
    if (n >= 40) stall_seen = 1'b1;
    @(negedge link_clk);
    // released lines must not keep showing the old value
    link_addr = ~a;
    link_wdata = ~d;
    repeat (gap) @(negedge link_clk);
  endtask : xfer
endmodule : rtcc_host_model

// *** test_rtcc_calendar.sv ***
// self-checking bench for the calendar and alarm register block
`timescale 1ns/1ns
module test_rtcc_calendar;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic srst, link_srst, tick_1hz, day_carry, month_carry, alarm_clear;
  logic link_access, link_rd, link_wr, link_done, link_busy, stall_seen;
  logic time_step, counting_blocked, alarm_flag;
  logic [7:0] link_addr, link_wdata, link_rdata;
  logic [6:0] cur_minute;
  logic [5:0] cur_hour, cur_date;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hB89C;
  int num_errors = 0;
  int comparisons = 0;
  int steps = 0;
  int base;
  logic [7:0] rst_tab[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                             8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
  logic [7:0] mask_tab[7] = '{8'h07, 8'h9F, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87};
  logic [7:0] mon_in[3] = '{8'h12, 8'h12, 8'h09};
  logic [7:0] mon_out[3] = '{8'h81, 8'h01, 8'h10};
  logic [7:0] yr_in[3] = '{8'h99, 8'h09, 8'h48};
  logic [7:0] yr_out[3] = '{8'h00, 8'h10, 8'h48};

  always #4 clock = ~clock;
  // link clock offset so its edges never meet the core edges
  initial begin
    #5;
    forever #32 link_clk = ~link_clk;
  end

  rtcc_calendar dut (.clock(clock), .srst(srst), .link_clk(link_clk), .link_srst(link_srst),
    .link_access(link_access), .link_rd(link_rd), .link_wr(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_rdata(link_rdata), .link_done(link_done),
    .link_busy(link_busy), .tick_1hz(tick_1hz), .time_step(time_step),
    .counting_blocked(counting_blocked), .day_carry(day_carry), .month_carry(month_carry),
    .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_date(cur_date),
    .alarm_clear(alarm_clear), .alarm_flag(alarm_flag));

  rtcc_host_model u_host (.link_clk(link_clk), .link_access(link_access), .link_rd(link_rd),
    .link_wr(link_wr), .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .link_done(link_done), .link_busy(link_busy),
    .stall_seen(stall_seen));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift

  task automatic conclude();
    // notes never answered count as mismatches
    num_errors += exp_q.size();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // read results are taken off the note queue as each read completes
  always @(posedge link_clk) begin
    if (link_done === 1'b1 && u_host.is_rd === 1'b1) begin
      if (exp_q.size() == 0) num_errors++;
      else check(link_rdata, exp_q.pop_front());
    end
  end

  // time steps counted for the blocking checks
  always @(posedge clock) begin
    if (time_step === 1'b1) steps++;
  end

  // a stuck host transfer ends the run
  always @(posedge stall_seen) begin
    num_errors++;
    conclude();
  end

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 8'h00);
  endtask : rd_exp

  // sel bits: tick, day carry, month carry, alarm clear
  task automatic pulse(input logic [3:0] sel);
    @(negedge clock);
    {tick_1hz, day_carry, month_carry, alarm_clear} = sel;
    @(negedge clock);
    {tick_1hz, day_carry, month_carry, alarm_clear} = 4'h0;
    repeat (3) @(negedge clock);
  endtask : pulse

  // bounded wait on a design level
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      conclude();
    end
  endtask : wait_lvl

  task automatic set_min(input logic [6:0] m);
    @(negedge clock);
    cur_minute = m;
    repeat (6) @(negedge clock);
  endtask : set_min

  initial begin
    {srst, link_srst} = 2'b11;
    {tick_1hz, day_carry, month_carry, alarm_clear} = 4'h0;
    cur_minute = 7'h00;
    cur_hour = 6'h00;
    cur_date = 6'h00;
    repeat (16) @(posedge clock);
    @(negedge clock);
    {srst, link_srst} = 2'b00;
    // reset values, time range read in one burst from pointer 02h
    u_host.set_access(1'b1);
    for (int a = 2; a <= 13; a++) rd_exp(8'(a), rst_tab[a - 2]);
    $display("reset values done");
    // random writes, unused bits read back as zero, slow host
    u_host.gap = 3;
    for (int i = 0; i < 7; i++) begin
      seed = xorshift(seed);
      u_host.xfer(1'b1, 8'(6 + i), seed[7:0]);
      rd_exp(8'(6 + i), seed[7:0] & mask_tab[i]);
    end
    u_host.gap = 0;
    // weekday wraps from 6 to 0
    u_host.xfer(1'b1, 8'h06, 8'h05);
    u_host.set_access(1'b0);
    pulse(4'h4);
    pulse(4'h4);
    u_host.set_access(1'b1);
    rd_exp(8'h06, 8'h00);
    // month carry: December wrap, year step, century toggle on 99
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(1'b1, 8'h07, mon_in[i]);
      u_host.xfer(1'b1, 8'h08, yr_in[i]);
      u_host.set_access(1'b0);
      pulse(4'h2);
      u_host.set_access(1'b1);
      rd_exp(8'h07, mon_out[i]);
      rd_exp(8'h08, yr_out[i]);
    end
    u_host.set_access(1'b0);
    $display("calendar counting done");
    // free tick gives exactly one step
    wait_lvl(counting_blocked, 1'b0);
    base = steps;
    pulse(4'h8);
    check(8'(steps - base), 8'h01);
    // ticks during an access: none applied, one kept for later
    u_host.set_access(1'b1);
    wait_lvl(counting_blocked, 1'b1);
    base = steps;
    repeat (3) pulse(4'h8);
    repeat (10) @(negedge clock);
    check(8'(steps - base), 8'h00);
    u_host.set_access(1'b0);
    wait_lvl(counting_blocked, 1'b0);
    repeat (10) @(negedge clock);
    check(8'(steps - base), 8'h01);
    $display("count blocking done");
    // minute alarm alone enabled; random match values, current time starts one off
    seed = xorshift(seed);
    set_min(seed[6:0] ^ 7'h01);
    cur_hour = seed[13:8] ^ 6'h01;
    cur_date = seed[21:16] ^ 6'h01;
    u_host.set_access(1'b1);
    u_host.xfer(1'b1, 8'h09, {1'b0, seed[6:0]});
    for (int a = 10; a <= 12; a++) u_host.xfer(1'b1, 8'(a), 8'h80);
    u_host.set_access(1'b0);
    pulse(4'h1);
    check({7'h00, alarm_flag}, 8'h00);
    set_min(seed[6:0]);
    check({7'h00, alarm_flag}, 8'h01);
    pulse(4'h1);
    repeat (6) @(negedge clock);
    check({7'h00, alarm_flag}, 8'h00);
    set_min(seed[6:0] ^ 7'h01);
    set_min(seed[6:0]);
    check({7'h00, alarm_flag}, 8'h01);
    // hour enabled, unused bit 6 ignored; minute disabled by bit 7 and kept off its value
    u_host.set_access(1'b1);
    u_host.xfer(1'b1, 8'h09, {1'b1, seed[6:0]});
    u_host.xfer(1'b1, 8'h0A, {2'b01, seed[13:8]});
    u_host.set_access(1'b0);
    pulse(4'h1);
    set_min(seed[6:0] ^ 7'h02);
    check({7'h00, alarm_flag}, 8'h00);
    @(negedge clock);
    cur_hour = seed[13:8];
    repeat (6) @(negedge clock);
    check({7'h00, alarm_flag}, 8'h01);
    // date and weekday enabled; the weekday counter stands at 0 here
    u_host.set_access(1'b1);
    u_host.xfer(1'b1, 8'h0A, 8'h80);
    u_host.xfer(1'b1, 8'h0B, {2'h0, seed[21:16]});
    u_host.xfer(1'b1, 8'h0C, 8'h00);
    u_host.set_access(1'b0);
    pulse(4'h1);
    check({7'h00, alarm_flag}, 8'h00);
    @(negedge clock);
    cur_date = seed[21:16];
    repeat (6) @(negedge clock);
    check({7'h00, alarm_flag}, 8'h01);
    pulse(4'h1);
    pulse(4'h4);
    check({7'h00, alarm_flag}, 8'h00);
    // a weekday match written to the new weekday gives a fresh match
    u_host.set_access(1'b1);
    u_host.xfer(1'b1, 8'h0C, 8'h01);
    u_host.set_access(1'b0);
    check({7'h00, alarm_flag}, 8'h01);
    $display("alarm done");
    conclude();
  end

  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : test_rtcc_calendar
